// File: attribute_port_access.sv
// Attribute access port: single-request read/write into the attribute cell array
`default_nettype none
`include "attr_port_params.svh"

module attribute_port_access (
    input  wire logic                   clock,          // Dedicated port clock
    input  wire logic                   sys_rst,        // Synchronous reset, active high
    input  wire logic                   attr_req_en,    // Request enable, one cycle
    input  wire logic                   attr_write_en,  // High: write, low: read
    input  wire attr_port_pkg::attr_addr_t attr_addr,   // Cell address
    input  wire attr_port_pkg::attr_data_t attr_write_data, // Write data
    output logic                        attr_done,      // Completion pulse
    output attr_port_pkg::attr_data_t   attr_read_data  // Read data at completion
);
    import attr_port_pkg::*;

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    attr_data_t  cell_reg [`ATTR_CELL_COUNT];   // Attribute cell array
    port_state_t state_reg;                     // Sequencer state
    port_state_t state_next;                    // Next sequencer state
    logic        is_write_reg;                  // Captured operation kind
    attr_addr_t  addr_reg;                      // Captured address
    attr_data_t  wdata_reg;                     // Captured write data
    logic [1:0]  wait_reg;                      // Access delay counter
    attr_data_t  rdata_reg;                     // Read data register

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire accept     = (state_reg == ST_IDLE || state_reg == ST_DONE) && attr_req_en;
    wire wait_over  = (wait_reg == 2'(`ATTR_ACCESS_CYC - 1));
    wire do_commit  = (state_reg == ST_BUSY) && wait_over && is_write_reg;

    // Next-state selection
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) state_next = ST_BUSY;
            end
            ST_BUSY: begin
                if (wait_over) state_next = ST_DONE;
            end
            ST_DONE: begin
                // Back-to-back request accepted in completion cycle
                state_next = accept ? ST_BUSY : ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // State register, rising edge only
    always_ff @(posedge clock) begin
        if (sys_rst) state_reg <= ST_IDLE;
        else         state_reg <= state_next;
    end

    // Delay counter restarts on each accepted request
    always_ff @(posedge clock) begin
        if (sys_rst || accept)       wait_reg <= 2'h0;
        else if (state_reg == ST_BUSY) wait_reg <= wait_reg + 2'h1;
    end

    // Capture request only when enabled; otherwise inputs ignored
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            is_write_reg <= 1'b0;
            addr_reg     <= '0;
            wdata_reg    <= '0;
        end else if (accept) begin
            is_write_reg <= attr_write_en;
            addr_reg     <= attr_addr;
            wdata_reg    <= attr_write_data;
        end
    end

    // Commit write data into the addressed cell before completion
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < `ATTR_CELL_COUNT; i++) cell_reg[i] <= `ATTR_CELL_RESET;
        end else if (do_commit) begin
            cell_reg[addr_reg] <= wdata_reg;
        end
    end

    // Read data loaded for read completion, zero otherwise
    always_ff @(posedge clock) begin
        if (sys_rst) rdata_reg <= '0;
        else if (state_reg == ST_BUSY && wait_over && !is_write_reg)
            rdata_reg <= cell_reg[addr_reg];
        else rdata_reg <= '0;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign attr_done      = (state_reg == ST_DONE);
    assign attr_read_data = rdata_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Request taken: enable high while idle or in the completion cycle
    sequence s_req;
        attr_req_en && (state_reg != ST_BUSY);
    endsequence

    // Completion low in the first wait cycle, high ATTR_ACCESS_CYC cycles later
    sequence s_done_after;
        !attr_done ##`ATTR_ACCESS_CYC attr_done;
    endsequence

    // Completion comes a fixed number of cycles after the request
    property p_done_timing;
        @(posedge clock) disable iff (sys_rst) s_req |=> s_done_after;
    endproperty
    a_done_timing: assert property (p_done_timing) else $error("done late or early");

    // Completion never stands for a second cycle
    property p_done_one;
        @(posedge clock) disable iff (sys_rst) attr_done |=> !attr_done;
    endproperty
    a_done_one: assert property (p_done_one) else $error("done longer than a cycle");

    // Every rising completion traces back to a request
    property p_done_cause;
        @(posedge clock) disable iff (sys_rst)
            $rose(attr_done) |-> $past(attr_req_en, 3);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without request");

    // Written word sits in its cell once the commit edge has passed
    property p_write_commit;
        @(posedge clock) disable iff (sys_rst)
            s_req ##0 attr_write_en |-> ##3 (cell_reg[$past(attr_addr, 3)]
                == $past(attr_write_data, 3));
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("write not committed");

    // Write completions carry a zero data word
    property p_read_zero_after_write;
        @(posedge clock) disable iff (sys_rst)
            attr_done && is_write_reg |-> attr_read_data == '0;
    endproperty
    a_read_zero_after_write: assert property (p_read_zero_after_write)
        else $error("read data on write");

    // Read completions carry the addressed cell
    property p_read_value;
        @(posedge clock) disable iff (sys_rst)
            attr_done && !is_write_reg |-> attr_read_data == cell_reg[addr_reg];
    endproperty
    a_read_value: assert property (p_read_value) else $error("read data wrong");

    // Qualifiers without an enable leave the captured request alone
    property p_ignore;
        @(posedge clock) disable iff (sys_rst)
            !attr_req_en |=> $stable(addr_reg) && $stable(wdata_reg) && $stable(is_write_reg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("input taken without enable");

    // Accepted request is captured whole at its own edge
    property p_capture;
        @(posedge clock) disable iff (sys_rst)
            s_req |=> addr_reg == $past(attr_addr) && wdata_reg == $past(attr_write_data)
                && is_write_reg == $past(attr_write_en);
    endproperty
    a_capture: assert property (p_capture) else $error("request not captured");

    // Read data bus rests at zero outside completion
    property p_read_quiet;
        @(posedge clock) disable iff (sys_rst)
            !attr_done |-> attr_read_data == '0;
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("stray read data");

    // Reset leaves the port with no completion and no data
    property p_reset_quiet;
        @(posedge clock) $past(sys_rst) |-> !attr_done && attr_read_data == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output after reset");

    // Write data already sits in its cell when completion shows
    property p_commit_done;
        @(posedge clock) disable iff (sys_rst)
            attr_done && is_write_reg |-> cell_reg[addr_reg] == wdata_reg;
    endproperty
    a_commit_done: assert property (p_commit_done) else $error("late commit");

    // Two quiet cycles follow every completion
    sequence s_quiet_gap;
        !attr_done ##1 !attr_done;
    endsequence

    // Completions stand a full access apart
    property p_done_gap;
        @(posedge clock) disable iff (sys_rst) attr_done |=> s_quiet_gap;
    endproperty
    a_done_gap: assert property (p_done_gap) else $error("completions too close");

    // An accepted request always starts the access
    property p_accept_busy;
        @(posedge clock) disable iff (sys_rst) s_req |=> state_reg == ST_BUSY;
    endproperty
    a_accept_busy: assert property (p_accept_busy) else $error("request not started");
endmodule : attribute_port_access
`default_nettype wire

// File: attr_port_params.svh
// Timing and size constants for the attribute access port
`ifndef ATTR_PORT_PARAMS_SVH
`define ATTR_PORT_PARAMS_SVH

// Address and data widths of the attribute cell array
`define ATTR_ADDR_W      9
`define ATTR_DATA_W      16
// Number of attribute cells
`define ATTR_CELL_COUNT  512
// Cycles spent committing a write or fetching a read before completion
`define ATTR_ACCESS_CYC  2
// Reset value of every attribute cell
`define ATTR_CELL_RESET  16'h0000

`endif

// File: attr_port_pkg.sv
// Types shared by the attribute access port
`default_nettype none
package attr_port_pkg;
    `include "attr_port_params.svh"

    // Cell address and cell contents
    typedef logic [`ATTR_ADDR_W-1:0] attr_addr_t;
    typedef logic [`ATTR_DATA_W-1:0] attr_data_t;

    // Port sequencer states, gray coded along idle -> busy -> done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11
    } port_state_t;
endpackage : attr_port_pkg
`default_nettype wire

// File: attr_requester.sv
// Fabric-side requester model for the attribute access port
`default_nettype none
module attr_requester
    import attr_port_pkg::*;
(
    input  wire logic       clock,           // Port clock
    input  wire logic       attr_done,       // Completion pulse
    input  wire attr_data_t attr_read_data,  // Read data
    output var  logic       attr_req_en,     // Request enable
    output var  logic       attr_write_en,   // Write select
    output var  attr_addr_t attr_addr,       // Cell address
    output var  attr_data_t attr_write_data  // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Request driving
    // ----------------------------------------
    // Quiet start, nothing requested
    initial begin
        attr_req_en     = 1'b0;
        attr_write_en   = 1'b0;
        attr_addr       = 9'h000;
        attr_write_data = 16'h0000;
    end
    // Qualifiers toggle while no request stands, so stale values prove nothing
    task automatic scramble();
        attr_req_en     = 1'b0;
        attr_write_en   = ~attr_write_en;
        attr_addr       = ~attr_addr;
        attr_write_data = ~attr_write_data;
    endtask : scramble
    // One request from a falling edge; returns read data and cycles taken
    task automatic access(input logic w, input attr_addr_t a, input attr_data_t d,
                          output attr_data_t q, output int lat);
        lat             = 0;
        attr_req_en     = 1'b1;
        attr_write_en   = w;
        attr_addr       = a;
        attr_write_data = d;
        do begin
            @(negedge clock);
            lat++;
            // Completion cycle left untouched so a follow-on request may start here
            if (attr_done !== 1'b1) scramble();
        end while (attr_done !== 1'b1 && lat < 20);
        q = attr_read_data;
    endtask : access
endmodule : attr_requester
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the attribute access port
`default_nettype none
`include "attr_port_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import attr_port_pkg::*;
    // ----------------------------------------
    // Signals and scoreboard
    // ----------------------------------------
    logic       clock, sys_rst, req_en, wr_en, done, last_done;  // Port wires, previous completion
    attr_addr_t addr;                                  // Cell address
    attr_data_t wdata, rdata;                          // Write and read data
    attr_data_t shadow [`ATTR_CELL_COUNT];             // Expected cells
    int         miscompares, tests_run, issued, finished;  // Counters
    int         seed = 32'hb853806f;                   // Fixed seed
    logic [31:0] r;                                    // Random draw
    attribute_port_access attribute_port_access_i (.clock(clock), .sys_rst(sys_rst),
        .attr_req_en(req_en), .attr_write_en(wr_en), .attr_addr(addr),
        .attr_write_data(wdata), .attr_done(done), .attr_read_data(rdata));
    attr_requester attr_requester_i (.clock(clock), .attr_done(done),
        .attr_read_data(rdata), .attr_req_en(req_en), .attr_write_en(wr_en),
        .attr_addr(addr), .attr_write_data(wdata));
    // Verdict and end of run
    task automatic complete_run();
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // Compare a data word
    task automatic chk_data(input attr_data_t got, input attr_data_t exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data
    // Compare a count
    task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_count
    // Read answer expected from the scoreboard; writes answer zero
    function automatic attr_data_t expect_read(input logic w, input attr_addr_t a);
        return w ? 16'h0000 : shadow[a];
    endfunction : expect_read
    // One checked request
    task automatic do_op(input logic w, input attr_addr_t a, input attr_data_t d);
        attr_data_t q;
        int         lat;
        issued++;
        attr_requester_i.access(w, a, d, q, lat);
        chk_count(lat, `ATTR_ACCESS_CYC + 1);
        chk_data(q, expect_read(w, a));
        if (w) shadow[a] = d;
    endtask : do_op
    // ----------------------------------------
    // Clock, monitor, sequence, watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Completion never stands two cycles
    always @(negedge clock) begin
        if (!sys_rst) begin
            chk_count({31'h0, done & last_done}, 32'h0);
            if (done === 1'b1) finished++;
        end
        last_done = done;
    end
    initial begin
        sys_rst = 1'b1;
        last_done = 1'b0;
        foreach (shadow[i]) shadow[i] = `ATTR_CELL_RESET;
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        do_op(1'b0, 9'h1FF, 16'h0000);
        do_op(1'b1, 9'h1FF, 16'hFFFF);
        do_op(1'b0, 9'h1FF, 16'h0000);
        do_op(1'b0, 9'h000, 16'h0000);
        for (int n = 0; n < 400; n++) begin
            r = $random(seed);
            do_op(r[31], r[24:16], r[15:0]);
            repeat (r[30:29] & {2{r[28]}}) begin
                @(negedge clock);
                attr_requester_i.scramble();
            end
        end
        repeat (4) @(negedge clock);
        chk_count(finished, issued);
        complete_run();
    end
    initial begin
        #40000;
        miscompares++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
